// *** core/fsad_consts.svh ***
// Offsets, field positions, reset values and timing counts of the sensor auto-detect block
`ifndef FSAD_CONSTS_SVH
`define FSAD_CONSTS_SVH
// Register byte offsets
`define FSAD_CFG_OFS 8'h00
`define FSAD_PARAM_OFS 8'h04
`define FSAD_STS_OFS 8'h08
`define FSAD_CLR_OFS 8'h0c
`define FSAD_EN_OFS 8'h10
`define FSAD_LOG_OFS 8'h14
`define FSAD_LOGCLR_OFS 8'h18
`define FSAD_CNT_OFS 8'h20
// Status bit positions
`define FSAD_ST_PCOMM 0
`define FSAD_ST_PWPF 1
`define FSAD_ST_SCOMM 2
`define FSAD_ST_SWPF 3
`define FSAD_ST_LOGGED 4
`define FSAD_ST_DONE 5
// Reset values
`define FSAD_FCC_RST 10'h320
`define FSAD_CONN_RST 4'h1
`define FSAD_PF_RST 8'h00
`define FSAD_NF_RST 8'h00
// Config log capacity
`define FSAD_LOG_MAX 6'h32
// Restricted variant country codes
`define FSAD_CC_R0 10'h0c4
`define FSAD_CC_R1 10'h0c7
`define FSAD_CC_R2 10'h127
`define FSAD_CC_R3 10'h128
// Info code display time
`define FSAD_INFO_HOLD_MS 5000
`define FSAD_CLK_KHZ 100000
`endif

// *** core/fsad_info_hold.sv ***
// Retriggerable hold timer for the fault information display
`timescale 1ns/100ps
`include "fsad_consts.svh"
module fsad_info_hold #(
  parameter int HOLD_CYCLES = `FSAD_INFO_HOLD_MS * `FSAD_CLK_KHZ
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  output logic active
);
  // Registered state and its next value
  fsad_pkg::fsad_hold_t hold_reg;
  fsad_pkg::fsad_hold_t hold_next;

  // Reload on each fault, then count down
  always_comb begin
    hold_next = hold_reg;
    if (start) begin
      hold_next.cnt = 29'(HOLD_CYCLES - 1);
    end else if (hold_reg.cnt != 29'h0) begin
      hold_next.cnt = hold_reg.cnt - 29'h1;
    end
    // Stays high for exactly the hold count
    hold_next.active = start || (hold_reg.cnt != 29'h0);
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_reg <= '0;
    end else begin
      hold_reg <= hold_next;
    end
  end

  assign active = hold_reg.active;
endmodule : fsad_info_hold

// *** core/fsad_pkg.sv ***
// Types of the sensor auto-detect block
package fsad_pkg;
  // Detect sequencer states
  typedef enum logic [1:0] {FSAD_IDLE, FSAD_WAIT_PRI, FSAD_WAIT_SEC} fsad_state_t;

  // Whole state of the top module
  typedef struct packed {
    fsad_state_t state;
    logic lid_s1;
    logic lid_s2;
    logic lid_d;
    logic armed;
    logic [9:0] fcc;
    logic [3:0] conn;
    logic [7:0] pf;
    logic [7:0] nf;
    logic [5:0] sts;
    logic [5:0] en;
    logic [5:0] log_cnt;
    logic mismatch;
    logic cfg_log;
    logic fault;
    logic req;
    logic sel;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
    logic cnt_en;
    logic [5:0] pin_s1;
    logic [5:0] pin_s2;
    logic [5:0] pin_d;
    logic [5:0][15:0] cnt;
  } fsad_top_t;

  // State of the info hold timer
  typedef struct packed {
    logic [28:0] cnt;
    logic active;
  } fsad_hold_t;
endpackage : fsad_pkg

// *** core/fsad_top.sv ***
// Flow sensor auto-detect: reassembly trigger, sensor reads, config log, info codes, pulse counters
//
// Summary of operation
// - Six pulse inputs: two flow, four auxiliary.
// - Both flow inputs share one setting.
// - Codes 1xx, 4xx, 5xx are valid fixed.
// - Detection enabled only with code 8xx.
// - Read sensors at start-up, adapt configuration; code reads only after a separation and rejoin.
// - Separation then rejoin starts detection.
// - Log entry on primary nominal flow change.
// - No detection on restricted country codes.
// - Primary sensor alone sets the configuration.
// - Secondary change: info code, no log.
// - Mismatch info holds until sensors match.
// - Primary change writes log entry unless log full or restricted.
// - Differing sensors raise an info code.
// - Two-sensor detect needs type 2/8, 8xx.
// - Comm or pulse-figure fault shown 5 s.
// - At most 50 logged changes until reset.
// - Full log rejects differing primary size.
`timescale 1ns/100ps
`include "fsad_consts.svh"
module fsad_top #(
  parameter int INFO_HOLD_CYCLES = `FSAD_INFO_HOLD_MS * `FSAD_CLK_KHZ
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic lid_closed,
  input wire logic [5:0] pulse_in,
  output logic sensor_req,
  output logic sensor_sel,
  input wire logic rsp_valid,
  input wire logic rsp_err,
  input wire logic [7:0] rsp_pulse_fig,
  input wire logic [7:0] rsp_nom_flow,
  input wire logic [9:0] rsp_country,
  output logic cfg_log_pulse,
  output logic mismatch_info,
  output logic info_show,
  output logic count_en,
  output logic irq
);
  // Registered state and its next value
  fsad_pkg::fsad_top_t s_reg;
  fsad_pkg::fsad_top_t s_next;
  logic hold_active; // Fault display timer running
  logic cnt_go; // Counting allowed on flow inputs
  logic trig; // Reassembly seen with detect enabled
  logic acc; // APB access edge
  logic rsp_restricted; // Responding sensor is a restricted variant
  logic rsp_differs; // Response differs from active setting

  // Hundreds digit of the flow config code
  function automatic logic [3:0] code_group(input logic [9:0] f);
    logic [9:0] q;
    q = f / 10'h064;
    return q[3:0];
  endfunction : code_group

  // Restricted variant country codes
  function automatic logic restricted(input logic [9:0] c);
    return (c == `FSAD_CC_R0) || (c == `FSAD_CC_R1) || (c == `FSAD_CC_R2) || (c == `FSAD_CC_R3);
  endfunction : restricted

  // Connection types that carry two sensors
  function automatic logic two_sensor(input logic [3:0] t);
    return (t == 4'h2) || (t == 4'h8);
  endfunction : two_sensor

  // Register read decode; bit 32 flags an unmapped address
  function automatic logic [32:0] rd_mux(input logic [7:0] a, input fsad_pkg::fsad_top_t s);
    logic [32:0] r;
    r = 33'h0;
    case (a)
      `FSAD_CFG_OFS: r = {17'h0, s.conn, 2'h0, s.fcc};
      `FSAD_PARAM_OFS: r = {17'h0, s.nf, s.pf};
      `FSAD_STS_OFS: r = {27'h0, s.sts};
      `FSAD_CLR_OFS: r = 33'h0;
      `FSAD_EN_OFS: r = {27'h0, s.en};
      `FSAD_LOG_OFS: r = {24'h0, hold_active, s.mismatch, 1'b0, s.log_cnt};
      `FSAD_LOGCLR_OFS: r = 33'h0;
      default: begin
        // Pulse counters at base plus four per input
        if (a[7:5] == 3'h1 && a[4:2] < 3'h6 && a[1:0] == 2'h0) begin
          r = {17'h0, s.cnt[a[4:2]]};
        end else begin
          r = 33'h100000000;
        end
      end
    endcase
    return r;
  endfunction : rd_mux

  // Fault information display hold
  fsad_info_hold #(
    .HOLD_CYCLES(INFO_HOLD_CYCLES)
  ) u_hold (
    .pclk(pclk),
    .presetn(presetn),
    .start(s_reg.fault),
    .active(hold_active)
  );

  // Helper terms
  always_comb begin
    // Registered counting permission
    cnt_go = s_reg.cnt_en;
    trig = s_reg.lid_s2 && !s_reg.lid_d && s_reg.armed &&
      (code_group(s_reg.fcc) == 4'h8) && (s_reg.state == fsad_pkg::FSAD_IDLE);
    acc = psel && penable && s_reg.pready;
    rsp_restricted = restricted(rsp_country);
    rsp_differs = (rsp_pulse_fig != s_reg.pf) || (rsp_nom_flow != s_reg.nf);
  end

  // Next-state logic of the whole block
  always_comb begin
    logic [5:0] set;
    logic [5:0] clr;
    logic [32:0] rd;
    set = 6'h0;
    clr = 6'h0;
    rd = 33'h0;
    s_next = s_reg;
    s_next.req = 1'b0;
    s_next.cfg_log = 1'b0;
    s_next.fault = 1'b0;

    // Two-stage pin synchronisers
    s_next.lid_s1 = lid_closed;
    s_next.lid_s2 = s_reg.lid_s1;
    s_next.lid_d = s_reg.lid_s2;
    s_next.pin_s1 = pulse_in;
    s_next.pin_s2 = s_reg.pin_s1;
    s_next.pin_d = s_reg.pin_s2;

    // Arm on separation, disarm on every rejoin
    if (!s_reg.lid_s2) begin
      s_next.armed = 1'b1;
    end else if (!s_reg.lid_d) begin
      s_next.armed = 1'b0;
    end

    // Six counters; aux inputs always count
    for (int i = 0; i < 6; i++) begin
      if (s_reg.pin_s2[i] && !s_reg.pin_d[i] && (i >= 2 || cnt_go)) begin
        s_next.cnt[i] = s_reg.cnt[i] + 16'h0001;
      end
    end

    // Detect sequencer
    case (s_reg.state)
      fsad_pkg::FSAD_IDLE: begin
        // Start by reading the primary sensor
        if (trig) begin
          s_next.req = 1'b1;
          s_next.sel = 1'b0;
          s_next.state = fsad_pkg::FSAD_WAIT_PRI;
        end
      end
      fsad_pkg::FSAD_WAIT_PRI: begin
        if (rsp_valid) begin
          if (rsp_err) begin
            set[`FSAD_ST_PCOMM] = 1'b1;
          end else if (rsp_restricted) begin
            s_next.pf = s_reg.pf;
          end else if (rsp_differs) begin
            if (s_reg.log_cnt >= `FSAD_LOG_MAX) begin
              // Full log: reject, flag wrong figure
              set[`FSAD_ST_PWPF] = 1'b1;
            end else begin
              s_next.pf = rsp_pulse_fig;
              s_next.nf = rsp_nom_flow;
              s_next.log_cnt = s_reg.log_cnt + 6'h01;
              s_next.cfg_log = 1'b1;
              set[`FSAD_ST_LOGGED] = 1'b1;
            end
          end
          // Secondary read only for two-sensor types
          if (two_sensor(s_reg.conn) && code_group(s_reg.fcc) == 4'h8) begin
            s_next.req = 1'b1;
            s_next.sel = 1'b1;
            s_next.state = fsad_pkg::FSAD_WAIT_SEC;
          end else begin
            set[`FSAD_ST_DONE] = 1'b1;
            s_next.state = fsad_pkg::FSAD_IDLE;
          end
        end
      end
      fsad_pkg::FSAD_WAIT_SEC: begin
        if (rsp_valid) begin
          if (rsp_err) begin
            set[`FSAD_ST_SCOMM] = 1'b1;
          end else if (!rsp_restricted) begin
            s_next.mismatch = rsp_differs;
            set[`FSAD_ST_SWPF] = rsp_differs;
          end
          set[`FSAD_ST_DONE] = 1'b1;
          s_next.state = fsad_pkg::FSAD_IDLE;
        end
      end
      default: begin
        s_next.state = fsad_pkg::FSAD_IDLE;
      end
    endcase

    // Any fault restarts the display hold
    s_next.fault = set[`FSAD_ST_PCOMM] || set[`FSAD_ST_PWPF] || set[`FSAD_ST_SCOMM] || set[`FSAD_ST_SWPF];

    // APB writes take effect on the access edge
    if (acc && pwrite) begin
      case (paddr)
        `FSAD_CFG_OFS: begin
          s_next.fcc = pwdata[9:0];
          s_next.conn = pwdata[15:12];
        end
        `FSAD_CLR_OFS: clr = pwdata[5:0];
        `FSAD_EN_OFS: s_next.en = pwdata[5:0];
        // Full reset empties the config log
        `FSAD_LOGCLR_OFS: if (pwdata[0]) s_next.log_cnt = 6'h00;
        default: s_next.en = s_reg.en;
      endcase
    end

    // Valid fixed groups plus detect group
    s_next.cnt_en = (s_next.state == fsad_pkg::FSAD_IDLE) &&
      (code_group(s_next.fcc) inside {4'h1, 4'h4, 4'h5, 4'h8});

    // Sticky status; a new event beats a same-cycle clear
    s_next.sts = (s_reg.sts & ~clr) | set;
    s_next.irq = |(s_next.sts & s_reg.en);

    // Zero-wait slave: answer in the first access cycle
    s_next.pready = psel && !penable;
    if (psel && !penable) begin
      rd = rd_mux(paddr, s_reg);
      s_next.prdata = pwrite ? 32'h0 : rd[31:0];
      s_next.pslverr = rd[32];
    end else begin
      s_next.pslverr = 1'b0;
    end
  end

  // State register; only constants under reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      s_reg.state <= fsad_pkg::FSAD_IDLE;
      s_reg.fcc <= `FSAD_FCC_RST;
      s_reg.conn <= `FSAD_CONN_RST;
      s_reg.pf <= `FSAD_PF_RST;
      s_reg.nf <= `FSAD_NF_RST;
      // Lid taken as joined, so release shows no false rejoin
      s_reg.lid_s1 <= 1'b1;
      s_reg.lid_s2 <= 1'b1;
      s_reg.lid_d <= 1'b1;
      // Reset code is in the detect group and idle
      s_reg.cnt_en <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from flops
  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign sensor_req = s_reg.req;
  assign sensor_sel = s_reg.sel;
  assign cfg_log_pulse = s_reg.cfg_log;
  assign mismatch_info = s_reg.mismatch;
  assign info_show = hold_active;
  assign irq = s_reg.irq;
  // Flow inputs paused while a detect runs or config is invalid
  assign count_en = s_reg.cnt_en;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Good unrestricted response in the primary and secondary wait states
  sequence s_pri_ok;
    s_reg.state == fsad_pkg::FSAD_WAIT_PRI && rsp_valid && !rsp_err && !rsp_restricted;
  endsequence
  sequence s_sec_ok;
    s_reg.state == fsad_pkg::FSAD_WAIT_SEC && rsp_valid && !rsp_err && !rsp_restricted;
  endsequence

  property p_req_only_8xx;
    sensor_req |-> code_group($past(s_reg.fcc)) == 4'h8;
  endproperty
  a_req_only_8xx: assert property (p_req_only_8xx) else $error("sensor read without 8xx code");

  property p_sec_two;
    sensor_req && sensor_sel |-> two_sensor(s_reg.conn);
  endproperty
  a_sec_two: assert property (p_sec_two) else $error("secondary read on single type");

  property p_no_count_busy;
    s_reg.state != fsad_pkg::FSAD_IDLE |-> !count_en ##1 ($stable(s_reg.cnt[0]) && $stable(s_reg.cnt[1]));
  endproperty
  a_no_count_busy: assert property (p_no_count_busy) else $error("counting during detect");

  property p_log_step;
    cfg_log_pulse |-> s_reg.log_cnt == $past(s_reg.log_cnt) + 6'h01;
  endproperty
  a_log_step: assert property (p_log_step) else $error("log entry without count step");

  property p_log_cap;
    s_reg.log_cnt <= `FSAD_LOG_MAX;
  endproperty
  a_log_cap: assert property (p_log_cap) else $error("config log above capacity");

  property p_full_reject;
    s_pri_ok and (rsp_differs && s_reg.log_cnt == `FSAD_LOG_MAX) |=> s_reg.sts[`FSAD_ST_PWPF] && !cfg_log_pulse;
  endproperty
  a_full_reject: assert property (p_full_reject) else $error("full log accepted change");

  property p_pri_change_logs;
    s_pri_ok and (rsp_differs && s_reg.log_cnt < `FSAD_LOG_MAX) |=> cfg_log_pulse;
  endproperty
  a_pri_change_logs: assert property (p_pri_change_logs) else $error("primary change not logged");

  property p_sec_no_log;
    s_reg.state == fsad_pkg::FSAD_WAIT_SEC |=> !cfg_log_pulse;
  endproperty
  a_sec_no_log: assert property (p_sec_no_log) else $error("secondary caused log entry");

  property p_mismatch_set;
    s_sec_ok and rsp_differs |=> mismatch_info ##1 info_show;
  endproperty
  a_mismatch_set: assert property (p_mismatch_set) else $error("mismatch not flagged");

  property p_mismatch_hold;
    mismatch_info && !(s_reg.state == fsad_pkg::FSAD_WAIT_SEC && rsp_valid && !rsp_err && !rsp_restricted &&
      !rsp_differs) |=> mismatch_info;
  endproperty
  a_mismatch_hold: assert property (p_mismatch_hold) else $error("mismatch dropped early");

  property p_restricted;
    s_reg.state == fsad_pkg::FSAD_WAIT_PRI && rsp_valid && rsp_restricted |=> !cfg_log_pulse;
  endproperty
  a_restricted: assert property (p_restricted) else $error("restricted sensor adopted");

  property p_trig_req;
    trig |=> sensor_req && !sensor_sel;
  endproperty
  a_trig_req: assert property (p_trig_req) else $error("rejoin did not start detect");
endmodule : fsad_top

// *** tb/fsad_sensor_model.sv ***
// Behavioural model of one or two flow sensors on the data link
`timescale 1ns/100ps
module fsad_sensor_model (
  input wire logic pclk,
  input wire logic sensor_req,
  input wire logic sensor_sel,
  input wire logic [15:0] pri,
  input wire logic [15:0] sec,
  input wire logic [9:0] country,
  input wire logic fail,
  input wire logic [3:0] lag,
  output logic rsp_valid,
  output logic rsp_err,
  output logic [7:0] rsp_pulse_fig,
  output logic [7:0] rsp_nom_flow,
  output logic [9:0] rsp_country
);
  int wait_cnt = -1; // Cycles left before answering, -1 idle
  logic sel_q = 1'b0; // Which sensor was asked
  initial begin
    rsp_valid = 1'b0;
    rsp_err = 1'b0;
    {rsp_nom_flow, rsp_pulse_fig, rsp_country} = '0;
  end
  // Answer lag+1 cycles after the request is sampled; released lines invert so stale data never looks valid
  always @(posedge pclk) begin
    rsp_valid <= (sensor_req !== 1'b1) && (wait_cnt == 0);
    if (rsp_valid) begin
      {rsp_err, rsp_nom_flow, rsp_pulse_fig, rsp_country} <= ~{rsp_err, rsp_nom_flow, rsp_pulse_fig, rsp_country};
    end
    if (sensor_req === 1'b1) begin
      sel_q <= sensor_sel;
      wait_cnt <= int'(lag);
    end else if (wait_cnt == 0) begin
      {rsp_nom_flow, rsp_pulse_fig} <= sel_q ? sec : pri;
      rsp_country <= country;
      rsp_err <= fail;
      wait_cnt <= -1;
    end else if (wait_cnt > 0) begin
      wait_cnt <= wait_cnt - 1;
    end
  end
endmodule : fsad_sensor_model

// *** tb/testbench.sv ***
// Self-checking bench for the flow sensor auto-detect block
`timescale 1ns/100ps
`include "fsad_consts.svh"
module testbench;
  localparam int HOLD = 20; // Short info hold keeps the run brief
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, lid_closed, fail;
  logic sensor_req, sensor_sel, rsp_valid, rsp_err, cfg_log_pulse, mismatch_info, info_show, count_en, irq;
  logic [7:0] paddr, rsp_pulse_fig, rsp_nom_flow;
  logic [31:0] pwdata, prdata, q;
  logic [5:0] pulse_in;
  logic [9:0] rsp_country, country;
  logic [15:0] pri, sec;
  logic [3:0] lag;
  logic e;
  int miscompares, compares, req_seen, log_seen, n0;
  int codes[4] = '{100, 400, 500, 200};
  fsad_top #(.INFO_HOLD_CYCLES(HOLD)) u_fsad_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lid_closed(lid_closed), .pulse_in(pulse_in), .sensor_req(sensor_req),
    .sensor_sel(sensor_sel), .rsp_valid(rsp_valid), .rsp_err(rsp_err), .rsp_pulse_fig(rsp_pulse_fig),
    .rsp_nom_flow(rsp_nom_flow), .rsp_country(rsp_country), .cfg_log_pulse(cfg_log_pulse),
    .mismatch_info(mismatch_info), .info_show(info_show), .count_en(count_en), .irq(irq));
  fsad_sensor_model u_fsad_sensor_model (.pclk(pclk), .sensor_req(sensor_req), .sensor_sel(sensor_sel),
    .pri(pri), .sec(sec), .country(country), .fail(fail), .lag(lag), .rsp_valid(rsp_valid),
    .rsp_err(rsp_err), .rsp_pulse_fig(rsp_pulse_fig), .rsp_nom_flow(rsp_nom_flow), .rsp_country(rsp_country));
  // Free running clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Count link requests and log pulses seen at the ports
  always @(posedge pclk) begin
    if (sensor_req === 1'b1) req_seen++;
    if (cfg_log_pulse === 1'b1) log_seen++;
  end
  task automatic results;
    if (miscompares == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      results;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge so a following call never re-raises psel in this step
    @(posedge pclk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check("read data", exp, q);
    check("pslverr", 32'h0, {31'h0, e});
  endtask : rd
  // Separate and rejoin top and base, then wait for the detect to finish, or 30 cycles when wait_done is low
  task automatic rejoin(input logic wait_done);
    int n;
    apb(1'b1, `FSAD_CLR_OFS, 32'h3f);
    lid_closed <= 1'b0;
    repeat (5) @(posedge pclk);
    lid_closed <= 1'b1;
    if (wait_done) begin
      n = 0;
      do begin
        apb(1'b0, `FSAD_STS_OFS, 32'h0);
        n++;
      end while (q[5] !== 1'b1 && n < 100);
      if (n >= 100) begin
        miscompares++;
        results;
      end
    end else repeat (30) @(posedge pclk);
  endtask : rejoin
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, pulse_in, fail, lag, country} = '0;
    lid_closed = 1'b1;
    pri = 16'h3412;
    sec = 16'h3412;
    {miscompares, compares, req_seen, log_seen} = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`FSAD_CFG_OFS, 32'h1320);
    rd(`FSAD_PARAM_OFS, 32'h0);
    rd(`FSAD_STS_OFS, 32'h0);
    rd(`FSAD_LOG_OFS, 32'h0);
    check("count_en", 32'h1, {31'h0, count_en});
    apb(1'b0, 8'h1c, 32'h0);
    check("unmapped pslverr", 32'h1, {31'h0, e});
    apb(1'b1, `FSAD_PARAM_OFS, 32'hffff);
    rd(`FSAD_PARAM_OFS, 32'h0);
    rejoin(1'b1);
    rd(`FSAD_PARAM_OFS, 32'h3412);
    rd(`FSAD_LOG_OFS, 32'h1);
    check("log pulses", 32'd1, log_seen);
    check("requests", 32'd1, req_seen);
    lag <= 4'h7;
    rejoin(1'b1);
    rd(`FSAD_STS_OFS, 32'h20);
    apb(1'b1, `FSAD_CFG_OFS, 32'h2320);
    sec <= 16'h3512;
    rejoin(1'b1);
    check("requests", 32'd4, req_seen);
    check("mismatch_info", 32'h1, {31'h0, mismatch_info});
    rd(`FSAD_LOG_OFS, 32'h181);
    rd(`FSAD_STS_OFS, 32'h28);
    sec <= 16'h3412;
    rejoin(1'b1);
    check("mismatch_info", 32'h0, {31'h0, mismatch_info});
    apb(1'b1, `FSAD_CFG_OFS, 32'h8320);
    pri <= 16'h2211;
    lag <= 4'h0;
    rejoin(1'b1);
    rd(`FSAD_PARAM_OFS, 32'h2211);
    rd(`FSAD_STS_OFS, 32'h38);
    apb(1'b1, `FSAD_CFG_OFS, 32'h1320);
    pri <= 16'h7777;
    foreach (codes[i]) begin
      country <= (i == 0) ? 10'd196 : (i == 1) ? 10'd199 : (i == 2) ? 10'd295 : 10'd296;
      rejoin(1'b1);
      rd(`FSAD_PARAM_OFS, 32'h2211);
    end
    country <= 10'd0;
    fail <= 1'b1;
    rejoin(1'b1);
    fail <= 1'b0;
    rd(`FSAD_STS_OFS, 32'h21);
    check("info_show", 32'h1, {31'h0, info_show});
    apb(1'b1, `FSAD_EN_OFS, 32'h1);
    @(posedge pclk);
    check("irq", 32'h1, {31'h0, irq});
    apb(1'b1, `FSAD_EN_OFS, 32'h0);
    @(posedge pclk);
    check("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, `FSAD_EN_OFS, 32'h1);
    apb(1'b1, `FSAD_CLR_OFS, 32'h1);
    repeat (HOLD + 4) @(posedge pclk);
    check("irq cleared", 32'h0, {31'h0, irq});
    check("info_show", 32'h0, {31'h0, info_show});
    foreach (codes[i]) begin
      apb(1'b1, `FSAD_CFG_OFS, 32'h1000 | codes[i]);
      n0 = req_seen;
      rejoin(1'b0);
      check("requests", n0, req_seen);
      check("count_en", {31'h0, codes[i] != 200}, {31'h0, count_en});
    end
    apb(1'b1, `FSAD_CFG_OFS, 32'h1320);
    apb(1'b1, `FSAD_LOGCLR_OFS, 32'h1);
    rd(`FSAD_LOG_OFS, 32'h80);
    for (int i = 0; i < 50; i++) begin
      pri <= i[0] ? 16'h0101 : 16'h0202;
      rejoin(1'b1);
    end
    rd(`FSAD_LOG_OFS, 32'hb2);
    pri <= 16'h0303;
    rejoin(1'b1);
    rd(`FSAD_STS_OFS, 32'h22);
    rd(`FSAD_PARAM_OFS, 32'h0101);
    for (int i = 0; i < 6; i++) begin
      repeat (i + 1) begin
        pulse_in[i] <= 1'b1;
        repeat (2) @(posedge pclk);
        pulse_in[i] <= 1'b0;
        repeat (2) @(posedge pclk);
      end
    end
    repeat (5) @(posedge pclk);
    for (int i = 0; i < 6; i++) rd(`FSAD_CNT_OFS + 8'(4 * i), 32'(i + 1));
    results;
  end
endmodule : testbench
